// >>> hdl/umc_pkg.sv
/*
 * Constants, types and helpers shared by the USB miscellaneous control block.
 * Assumes one 125 MHz clock and an APB register port with 32-bit data.
 */
// What this block does
// RULE1: End of bus reset sets end-of-reset flag; interrupt when enabled.
// RULE2: Bus reset returns all registers to reset values, controller stays enabled.
// RULE3: Firmware clears end-of-reset flag before the next reset is reported.
// RULE4: STALL only on control, bulk and interrupt endpoints, never isochronous.
// RULE5: Stall request on selected endpoint answers host's next request with STALL.
// RULE6: Firmware clears endpoint transfer flags before requesting a stall.
// RULE7: Transmitted STALL sets stall-sent flag; interrupt when enabled.
// RULE8: Firmware clears stall request and stall-sent flag after each STALL.
// RULE9: Valid SETUP PID on a control endpoint clears its stall request.
// RULE10: After clear-halt, firmware resets the endpoint so toggling restarts.
// RULE11: Start-of-frame PID sets frame-start flag; interrupt when enabled.
// RULE12: Firmware clears frame-start flag so the next frame gets reported.
// RULE13: Every start-of-frame token overwrites frame number low and high registers.
// RULE14: Last frame token sets CRC-good when valid, CRC-bad when corrupted.
// RULE15: Accepted DATA0 sets endpoint toggle bit; accepted DATA1 clears it.
// RULE16: Firmware endpoint reset clears the endpoint toggle bit.
// RULE17: Control SETUP starts with DATA0, then toggles, status ends with DATA1.
// RULE18: Firmware ignores toggle state on isochronous endpoints.
// RULE19: With clocks running, idle bus sets suspend flag; interrupt when enabled.
// RULE20: Clearing suspend flag idles the pad; firmware gates clock or re-suspends 3ms later.
// RULE21: Resume detection stays active with pad idle and clocks stopped.
// RULE22: Firmware sets USB clock gate before clearing PLL enable.
// RULE23: Interrupt asserted while any flag and its enable are set.
package umc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned UMC_CLK_PERIOD_NS       = 8;
  localparam int unsigned UMC_SUSPEND_IDLE_NS     = 3000000;
  localparam int unsigned UMC_SUSPEND_IDLE_CYCLES =
    (UMC_SUSPEND_IDLE_NS + UMC_CLK_PERIOD_NS - 1) / UMC_CLK_PERIOD_NS;
  localparam int unsigned UMC_IDLE_CNT_W          = 20;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int unsigned UMC_NUM_EP = 8;
  localparam int unsigned UMC_EP_W   = 3;
  localparam int unsigned UMC_EVT_W  = 3;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] UMC_OFS_CONTROL    = 8'h00;
  localparam logic [7:0] UMC_OFS_EVENT      = 8'h04;
  localparam logic [7:0] UMC_OFS_EVENT_EN   = 8'h08;
  localparam logic [7:0] UMC_OFS_EP_SELECT  = 8'h0c;
  localparam logic [7:0] UMC_OFS_EP_STATUS  = 8'h10;
  localparam logic [7:0] UMC_OFS_EP_CONFIG  = 8'h14;
  localparam logic [7:0] UMC_OFS_EP_RESET   = 8'h18;
  localparam logic [7:0] UMC_OFS_FRAME_LOW  = 8'h1c;
  localparam logic [7:0] UMC_OFS_FRAME_HIGH = 8'h20;
  localparam logic [7:0] UMC_OFS_EP_IRQ_EN  = 8'h24;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned UMC_CTL_ENABLE      = 0;
  localparam int unsigned UMC_CTL_CLOCK_GATE  = 1;
  localparam int unsigned UMC_EVT_SUSPEND     = 0;
  localparam int unsigned UMC_EVT_FRAME_START = 1;
  localparam int unsigned UMC_EVT_END_RESET   = 2;
  localparam int unsigned UMC_ST_STALL_SENT   = 1;
  localparam int unsigned UMC_ST_STALL_REQ    = 5;
  localparam int unsigned UMC_ST_TOGGLE       = 6;
  localparam int unsigned UMC_FH_CRC_BAD      = 4;
  localparam int unsigned UMC_FH_CRC_GOOD     = 5;
  localparam logic [UMC_EVT_W-1:0] UMC_EVT_RESET_VAL = 3'h0;
  localparam logic [UMC_EVT_W-1:0] UMC_EVT_AFTER_BUS_RESET = 3'h4;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    UMC_EP_CONTROL = 2'h0,
    UMC_EP_ISO     = 2'h1,
    UMC_EP_BULK    = 2'h2,
    UMC_EP_INTR    = 2'h3
  } umc_ep_kind_type;

  typedef enum logic [1:0] {
    UMC_SUS_ACTIVE    = 2'b00,
    UMC_SUS_SUSPENDED = 2'b01,
    UMC_SUS_PAD_IDLE  = 2'b11
  } umc_sus_state_type;

  // Events from the packet engine, each flag a one-cycle pulse
  typedef struct packed {
    logic                bus_reset_end;
    logic                sof_valid;
    logic                sof_crc_ok;
    logic [10:0]         sof_frame;
    logic                setup_pid;
    logic                data_accept;
    logic                data_pid1;
    logic                stall_sent;
    logic [UMC_EP_W-1:0] ep;
  } umc_link_evt_type;

  typedef struct packed {
    logic                  wr_status;
    logic                  wr_config;
    logic [UMC_NUM_EP-1:0] rst_mask;
    logic [UMC_EP_W-1:0]   sel;
    logic [7:0]            wdata;
  } umc_ep_cmd_type;

  function automatic logic umc_ep_match(logic [UMC_EP_W-1:0] ep, int unsigned idx);
    return ep == idx[UMC_EP_W-1:0];
  endfunction

endpackage

// >>> hdl/umc_idle_timer.sv
/*
 * Bus idle timer: pulses once per full idle interval while enabled.
 * Assumes the idle level comes synchronous from the line receiver.
 */
`timescale 1ns/1ps
module umc_idle_timer
  import umc_pkg::*;
#(
  parameter int unsigned IDLE_CYCLES = UMC_SUSPEND_IDLE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic enable_i,
  input  wire logic idle_i,
  output logic      pulse_o
);

  logic [UMC_IDLE_CNT_W-1:0] count;
  logic                      hit;

  assign hit = (count == UMC_IDLE_CNT_W'(IDLE_CYCLES - 1));

  // Restart after each pulse so an ungated clock reports again later
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= '0;
    end else if (!enable_i || !idle_i || hit) begin
      count <= '0;
    end else begin
      count <= count + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= enable_i && idle_i && hit; // RULE19
    end
  end

endmodule // umc_idle_timer

// >>> hdl/umc_ep_table.sv
/*
 * Per-endpoint stall, stall-sent, toggle and type state.
 * Assumes the packet engine drives the current token endpoint on evt_i.ep.
 */
`timescale 1ns/1ps
module umc_ep_table
  import umc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             flush_i,
  input  wire umc_ep_cmd_type   cmd_i,
  input  wire umc_link_evt_type evt_i,
  output logic [7:0]            sel_status_o,
  output umc_ep_kind_type       sel_kind_o,
  output logic                  link_stall_o,
  output logic                  link_data1_o,
  output logic [UMC_NUM_EP-1:0] stall_sent_o
);

  logic [UMC_NUM_EP-1:0] stall_req;
  logic [UMC_NUM_EP-1:0] stall_sent;
  logic [UMC_NUM_EP-1:0] toggle;
  umc_ep_kind_type       kind [UMC_NUM_EP];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < UMC_NUM_EP; i++) kind[i] <= UMC_EP_CONTROL;
    end else if (flush_i) begin
      for (int i = 0; i < UMC_NUM_EP; i++) kind[i] <= UMC_EP_CONTROL; // RULE2
    end else if (cmd_i.wr_config) begin
      kind[cmd_i.sel] <= umc_ep_kind_type'(cmd_i.wdata[1:0]);
    end
  end

  // Hardware clear by SETUP comes last so it beats a same-cycle write
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stall_req <= '0;
    end else if (flush_i) begin
      stall_req <= '0; // RULE2
    end else begin
      for (int i = 0; i < UMC_NUM_EP; i++) begin
        if (cmd_i.wr_status && umc_ep_match(cmd_i.sel, i) && kind[i] != UMC_EP_ISO) begin
          stall_req[i] <= cmd_i.wdata[UMC_ST_STALL_REQ]; // RULE4
        end
        if (evt_i.setup_pid && umc_ep_match(evt_i.ep, i) && kind[i] == UMC_EP_CONTROL) begin
          stall_req[i] <= 1'b0; // RULE9
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      stall_sent <= '0;
    end else if (flush_i) begin
      stall_sent <= '0;
    end else begin
      for (int i = 0; i < UMC_NUM_EP; i++) begin
        if (cmd_i.wr_status && umc_ep_match(cmd_i.sel, i) && !cmd_i.wdata[UMC_ST_STALL_SENT]) begin
          stall_sent[i] <= 1'b0;
        end
        if (evt_i.stall_sent && umc_ep_match(evt_i.ep, i)) begin
          stall_sent[i] <= 1'b1; // RULE7
        end
      end
    end
  end

  // Set means the last accepted packet was DATA0, so DATA1 comes next
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      toggle <= '0;
    end else if (flush_i) begin
      toggle <= '0;
    end else begin
      for (int i = 0; i < UMC_NUM_EP; i++) begin
        if (cmd_i.rst_mask[i]) begin
          toggle[i] <= 1'b0; // RULE16
        end
        if (umc_ep_match(evt_i.ep, i)) begin
          if (evt_i.setup_pid && kind[i] == UMC_EP_CONTROL) begin
            toggle[i] <= 1'b1; // RULE17
          end else if (evt_i.data_accept) begin
            toggle[i] <= !evt_i.data_pid1; // RULE15
          end
        end
      end
    end
  end

  always_comb begin
    sel_status_o                    = 8'h00;
    sel_status_o[UMC_ST_STALL_SENT] = stall_sent[cmd_i.sel];
    sel_status_o[UMC_ST_STALL_REQ]  = stall_req[cmd_i.sel];
    sel_status_o[UMC_ST_TOGGLE]     = toggle[cmd_i.sel];
  end

  assign sel_kind_o   = kind[cmd_i.sel];
  assign link_stall_o = stall_req[evt_i.ep] && kind[evt_i.ep] != UMC_EP_ISO; // RULE5
  assign link_data1_o = toggle[evt_i.ep];
  assign stall_sent_o = stall_sent;

endmodule // umc_ep_table

// >>> hdl/umc_misc_ctrl.sv
/*
 * USB miscellaneous control: bus reset, stall, frame, toggle and suspend.
 * Assumes an APB master on the same clock and a packet engine that
 * delivers synchronous one-cycle event pulses.
 */
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module umc_misc_ctrl
  import umc_pkg::*;
#(
  parameter int unsigned SUSPEND_IDLE_CYCLES = UMC_SUSPEND_IDLE_CYCLES
) (
  input  wire logic             CLK_I,
  input  wire logic             ARST_N_I,
  input  wire logic             PSEL_I,
  input  wire logic             PENABLE_I,
  input  wire logic             PWRITE_I,
  input  wire logic [7:0]       PADDR_I,
  input  wire logic [31:0]      PWDATA_I,
  output logic [31:0]           PRDATA_O,
  output logic                  PREADY_O,
  output logic                  PSLVERR_O,
  input  wire umc_link_evt_type LINK_EVT_I,
  input  wire logic             BUS_IDLE_I,
  input  wire logic             BUS_ACTIVE_I,
  output logic                  STALL_ANSWER_O,
  output logic                  TX_DATA1_O,
  output logic                  USB_ENABLE_O,
  output logic                  USB_CLOCK_GATE_O,
  output logic                  PAD_IDLE_O,
  output logic                  RESUME_DET_O,
  output logic                  USB_IRQ_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic                  usb_enable;
  logic                  usb_clock_gate;
  logic [UMC_EVT_W-1:0]  usb_event;
  logic [UMC_EVT_W-1:0]  next_usb_event;
  logic [UMC_EVT_W-1:0]  event_en;
  logic [UMC_EP_W-1:0]   endpoint_select;
  logic [UMC_NUM_EP-1:0] ep_irq_en;
  logic [7:0]            frame_number_low;
  logic [2:0]            frame_number_high;
  logic                  frame_crc_good;
  logic                  frame_crc_bad;
  umc_sus_state_type     sus_state;
  umc_sus_state_type     next_sus_state;
  logic                  bus_reset;
  logic                  wr_en;
  logic                  rd_setup;
  logic                  suspend_clear;
  logic                  idle_pulse;
  logic [7:0]            sel_status;
  umc_ep_kind_type       sel_kind;
  logic [UMC_NUM_EP-1:0] stall_sent_vec;
  umc_ep_cmd_type        ep_cmd;
  logic [31:0]           read_word;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic logic addr_mapped(logic [7:0] addr);
    return addr == UMC_OFS_CONTROL || addr == UMC_OFS_EVENT ||
           addr == UMC_OFS_EVENT_EN || addr == UMC_OFS_EP_SELECT ||
           addr == UMC_OFS_EP_STATUS || addr == UMC_OFS_EP_CONFIG ||
           addr == UMC_OFS_EP_RESET || addr == UMC_OFS_FRAME_LOW ||
           addr == UMC_OFS_FRAME_HIGH || addr == UMC_OFS_EP_IRQ_EN;
  endfunction

  function automatic logic wr_hit(logic en, logic [7:0] addr, logic [7:0] ofs);
    return en && addr == ofs;
  endfunction

  // Zero wait states: every access completes in its first access cycle
  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !addr_mapped(PADDR_I);
  assign wr_en     = PSEL_I && PENABLE_I && PWRITE_I && addr_mapped(PADDR_I);
  assign rd_setup  = PSEL_I && !PENABLE_I && !PWRITE_I;
  assign bus_reset = LINK_EVT_I.bus_reset_end;

  // Clearing a set suspend flag is the cue to idle the pad
  assign suspend_clear = wr_hit(wr_en, PADDR_I, UMC_OFS_EVENT) &&
                         usb_event[UMC_EVT_SUSPEND] && !PWDATA_I[UMC_EVT_SUSPEND];

  // ****************************************************************
  // Control register
  // ****************************************************************
  // Bus reset leaves the enable alone so the controller keeps running
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      usb_enable <= 1'b0;
    end else if (wr_hit(wr_en, PADDR_I, UMC_OFS_CONTROL)) begin
      usb_enable <= PWDATA_I[UMC_CTL_ENABLE]; // RULE2
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      usb_clock_gate <= 1'b0;
    end else if (bus_reset) begin
      usb_clock_gate <= 1'b0; // RULE2
    end else if (wr_hit(wr_en, PADDR_I, UMC_OFS_CONTROL)) begin
      usb_clock_gate <= PWDATA_I[UMC_CTL_CLOCK_GATE];
    end
  end

  // ****************************************************************
  // Event register
  // ****************************************************************
  // Write zero to clear; a hardware set in the same cycle wins
  always_comb begin
    next_usb_event = usb_event;
    if (wr_hit(wr_en, PADDR_I, UMC_OFS_EVENT)) begin
      next_usb_event = usb_event & PWDATA_I[UMC_EVT_W-1:0];
    end
    if (LINK_EVT_I.sof_valid) begin
      next_usb_event[UMC_EVT_FRAME_START] = 1'b1; // RULE11
    end
    if (idle_pulse) begin
      next_usb_event[UMC_EVT_SUSPEND] = 1'b1; // RULE19
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      usb_event <= UMC_EVT_RESET_VAL;
    end else if (bus_reset) begin
      usb_event <= UMC_EVT_AFTER_BUS_RESET; // RULE1
    end else begin
      usb_event <= next_usb_event;
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      event_en <= '0;
    end else if (bus_reset) begin
      event_en <= '0; // RULE2
    end else if (wr_hit(wr_en, PADDR_I, UMC_OFS_EVENT_EN)) begin
      event_en <= PWDATA_I[UMC_EVT_W-1:0];
    end
  end

  // ****************************************************************
  // Endpoint selection and interrupt enables
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      endpoint_select <= '0;
    end else if (bus_reset) begin
      endpoint_select <= '0; // RULE2
    end else if (wr_hit(wr_en, PADDR_I, UMC_OFS_EP_SELECT)) begin
      endpoint_select <= PWDATA_I[UMC_EP_W-1:0];
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ep_irq_en <= '0;
    end else if (bus_reset) begin
      ep_irq_en <= '0; // RULE2
    end else if (wr_hit(wr_en, PADDR_I, UMC_OFS_EP_IRQ_EN)) begin
      ep_irq_en <= PWDATA_I[UMC_NUM_EP-1:0];
    end
  end

  // Endpoint reset is a write-only strobe, one bit per endpoint
  always_comb begin
    ep_cmd           = '0;
    ep_cmd.wr_status = wr_hit(wr_en, PADDR_I, UMC_OFS_EP_STATUS);
    ep_cmd.wr_config = wr_hit(wr_en, PADDR_I, UMC_OFS_EP_CONFIG);
    ep_cmd.sel       = endpoint_select;
    ep_cmd.wdata     = PWDATA_I[7:0];
    if (wr_hit(wr_en, PADDR_I, UMC_OFS_EP_RESET)) begin
      ep_cmd.rst_mask = PWDATA_I[UMC_NUM_EP-1:0]; // RULE16
    end
  end

  umc_ep_table u_ep_table (
    .clk_i        (CLK_I),
    .arst_n_i     (ARST_N_I),
    .flush_i      (bus_reset),
    .cmd_i        (ep_cmd),
    .evt_i        (LINK_EVT_I),
    .sel_status_o (sel_status),
    .sel_kind_o   (sel_kind),
    .link_stall_o (STALL_ANSWER_O),
    .link_data1_o (TX_DATA1_O),
    .stall_sent_o (stall_sent_vec)
  );

  // ****************************************************************
  // Frame number capture
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      frame_number_low  <= 8'h00;
      frame_number_high <= 3'h0;
    end else if (bus_reset) begin
      frame_number_low  <= 8'h00;
      frame_number_high <= 3'h0;
    end else if (LINK_EVT_I.sof_valid) begin
      frame_number_low  <= LINK_EVT_I.sof_frame[7:0]; // RULE13
      frame_number_high <= LINK_EVT_I.sof_frame[10:8];
    end
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      frame_crc_good <= 1'b0;
      frame_crc_bad  <= 1'b0;
    end else if (bus_reset) begin
      frame_crc_good <= 1'b0;
      frame_crc_bad  <= 1'b0;
    end else if (LINK_EVT_I.sof_valid) begin
      frame_crc_good <= LINK_EVT_I.sof_crc_ok; // RULE14
      frame_crc_bad  <= !LINK_EVT_I.sof_crc_ok;
    end
  end

  // ****************************************************************
  // Suspend and pad control
  // ****************************************************************
  // Timer only runs with the clock ungated, so gating stops re-suspend
  umc_idle_timer #(
    .IDLE_CYCLES (SUSPEND_IDLE_CYCLES)
  ) u_idle_timer (
    .clk_i    (CLK_I),
    .arst_n_i (ARST_N_I),
    .enable_i (usb_enable && !usb_clock_gate), // RULE19
    .idle_i   (BUS_IDLE_I),
    .pulse_o  (idle_pulse)
  );

  always_comb begin
    next_sus_state = sus_state;
    unique case (sus_state)
      UMC_SUS_ACTIVE: begin
        if (idle_pulse) next_sus_state = UMC_SUS_SUSPENDED;
      end
      UMC_SUS_SUSPENDED: begin
        if (suspend_clear) next_sus_state = UMC_SUS_PAD_IDLE; // RULE20
      end
      UMC_SUS_PAD_IDLE: begin
        if (BUS_ACTIVE_I) begin
          next_sus_state = UMC_SUS_ACTIVE; // RULE21
        end else if (idle_pulse) begin
          next_sus_state = UMC_SUS_SUSPENDED; // RULE20
        end
      end
      default: next_sus_state = UMC_SUS_ACTIVE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sus_state <= UMC_SUS_ACTIVE;
    end else if (bus_reset) begin
      sus_state <= UMC_SUS_ACTIVE; // RULE2
    end else begin
      sus_state <= next_sus_state;
    end
  end

  // Resume path is pure logic so it works with the clock stopped
  assign RESUME_DET_O     = (sus_state == UMC_SUS_PAD_IDLE) && BUS_ACTIVE_I; // RULE21
  assign PAD_IDLE_O       = (sus_state == UMC_SUS_PAD_IDLE);
  assign USB_ENABLE_O     = usb_enable;
  assign USB_CLOCK_GATE_O = usb_clock_gate;

  // ****************************************************************
  // Interrupt request
  // ****************************************************************
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      USB_IRQ_O <= 1'b0;
    end else begin
      USB_IRQ_O <= (|(usb_event & event_en)) || (|(stall_sent_vec & ep_irq_en)); // RULE23
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  always_comb begin
    read_word = 32'h0000_0000;
    unique case (PADDR_I)
      UMC_OFS_CONTROL: begin
        read_word[UMC_CTL_ENABLE]     = usb_enable;
        read_word[UMC_CTL_CLOCK_GATE] = usb_clock_gate;
      end
      UMC_OFS_EVENT:      read_word[UMC_EVT_W-1:0]  = usb_event;
      UMC_OFS_EVENT_EN:   read_word[UMC_EVT_W-1:0]  = event_en;
      UMC_OFS_EP_SELECT:  read_word[UMC_EP_W-1:0]   = endpoint_select;
      UMC_OFS_EP_STATUS:  read_word[7:0]            = sel_status;
      UMC_OFS_EP_CONFIG:  read_word[1:0]            = sel_kind;
      UMC_OFS_FRAME_LOW:  read_word[7:0]            = frame_number_low;
      UMC_OFS_FRAME_HIGH: begin
        read_word[2:0]             = frame_number_high;
        read_word[UMC_FH_CRC_BAD]  = frame_crc_bad;
        read_word[UMC_FH_CRC_GOOD] = frame_crc_good;
      end
      UMC_OFS_EP_IRQ_EN:  read_word[UMC_NUM_EP-1:0] = ep_irq_en;
      default:            read_word                 = 32'h0000_0000;
    endcase
  end

  // Sampled in the setup cycle; holds through the access cycle
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA_O <= read_word;
    end
  end

endmodule // umc_misc_ctrl

// >>> verification/umc_misc_ctrl_checker.sv
/* Port checker for umc_misc_ctrl.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
module umc_misc_ctrl_checker
  import umc_pkg::*;
(
  input wire logic             CLK_I, ARST_N_I, PSEL_I, PENABLE_I, PREADY_O, PSLVERR_O,
  input wire umc_link_evt_type LINK_EVT_I,
  input wire logic             BUS_ACTIVE_I, STALL_ANSWER_O, TX_DATA1_O, USB_ENABLE_O,
  input wire logic             USB_CLOCK_GATE_O, PAD_IDLE_O, RESUME_DET_O, USB_IRQ_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  AST_RST_KEEP:
    assert property (LINK_EVT_I.bus_reset_end |=> USB_ENABLE_O == $past(USB_ENABLE_O)
      && !USB_CLOCK_GATE_O ##1 !PAD_IDLE_O) else $error("bus reset control state wrong");
  AST_RST_EP:
    assert property (LINK_EVT_I.bus_reset_end |=> !STALL_ANSWER_O && !TX_DATA1_O)
      else $error("bus reset left endpoint state");
  AST_RST_IRQ:
    assert property (LINK_EVT_I.bus_reset_end |-> ##2 !USB_IRQ_O)
      else $error("irq after bus reset");
  AST_TOGGLE:
    assert property (LINK_EVT_I.data_accept && !LINK_EVT_I.bus_reset_end ##1
      $stable(LINK_EVT_I.ep) |-> TX_DATA1_O == !$past(LINK_EVT_I.data_pid1))
      else $error("toggle wrong after accept");
  AST_SETUP:
    assert property (LINK_EVT_I.setup_pid && !LINK_EVT_I.bus_reset_end ##1
      $stable(LINK_EVT_I.ep) |-> !STALL_ANSWER_O && TX_DATA1_O) else $error("setup effect wrong");
  AST_RESUME:
    assert property (RESUME_DET_O == (PAD_IDLE_O && BUS_ACTIVE_I)) else $error("resume wrong");
  AST_WAKE:
    assert property (PAD_IDLE_O && BUS_ACTIVE_I |=> !PAD_IDLE_O) else $error("pad stays idle");
  AST_ERR:
    assert property (PSLVERR_O |-> PSEL_I && PENABLE_I) else $error("slverr outside access");
  AST_READY:
    assert property (PSEL_I && PENABLE_I |-> PREADY_O) else $error("pready low in access");
endmodule // umc_misc_ctrl_checker

// >>> verification/umc_host_model.sv
/* Host side model: drives packet engine event pulses.
   Assumes the bench calls send between clock edges. */
`timescale 1ns/1ps
module umc_host_model
  import umc_pkg::*;
(
  input  wire logic       clk_i,
  output umc_link_evt_type evt_o
);
  initial evt_o = '0;
  // Ep stays as token level; qualifiers turn to junk outside their pulse
  task automatic send(input umc_link_evt_type e);
    umc_link_evt_type q;
    q = '0;
    q.ep = e.ep;
    q.sof_frame = ~e.sof_frame;
    q.data_pid1 = ~e.data_pid1;
    @(posedge clk_i) evt_o <= e;
    @(posedge clk_i) evt_o <= q;
  endtask
endmodule // umc_host_model

// >>> verification/umc_misc_ctrl_tb.sv
/* Self-checking bench for umc_misc_ctrl.
   Assumes the host model and checker files are compiled first. */
`timescale 1ns/1ps
`define CHK(n, x, y) begin tests_run++; if ((y) !== (x)) begin err_count++; \
  $display("Error %s exp %h got %h", n, x, y); end end
module umc_misc_ctrl_tb;
  import umc_pkg::*;
  logic CLK_I = 0, ARST_N_I = 0, PSEL_I = 0, PENABLE_I = 0, PWRITE_I = 0, serr;
  logic BUS_IDLE_I = 0, BUS_ACTIVE_I = 0, PREADY_O, PSLVERR_O, STALL_ANSWER_O, TX_DATA1_O;
  logic USB_ENABLE_O, USB_CLOCK_GATE_O, PAD_IDLE_O, RESUME_DET_O, USB_IRQ_O;
  logic [7:0] PADDR_I = 0;
  logic [31:0] PWDATA_I = 0, PRDATA_O, rd;
  umc_link_evt_type LINK_EVT_I, e;
  int err_count = 0, tests_run = 0, n, i;
  always #4 CLK_I = ~CLK_I;
  umc_misc_ctrl #(.SUSPEND_IDLE_CYCLES(20)) dut_u (.*);
  umc_host_model h (.clk_i(CLK_I), .evt_o(LINK_EVT_I));
  task automatic results();
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I) begin PSEL_I <= 1; PWRITE_I <= w; PADDR_I <= a; PWDATA_I <= d; end
    @(posedge CLK_I) PENABLE_I <= 1;
    for (n = 0; n < 16; n++) begin @(posedge CLK_I); if (PREADY_O === 1'b1) break; end
    rd = PRDATA_O;
    serr = PSLVERR_O;
    PSEL_I <= 0;
    PENABLE_I <= 0;
    if (n == 16) begin err_count++; results(); end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
    xfer(0, a, 0);
    `CHK(nm, x, rd)
  endtask
  initial begin
    repeat (2) @(posedge CLK_I);
    ARST_N_I <= 1;
    rdc(UMC_OFS_CONTROL, 0, "control");
    xfer(0, 8'h40, 0);
    `CHK("slverr", 1'b1, serr)
    xfer(1, UMC_OFS_EVENT_EN, 2);
    e = '0; e.sof_valid = 1; e.sof_crc_ok = 1; e.sof_frame = 11'h5a3; h.send(e);
    @(posedge CLK_I); #1 `CHK("irq", 1'b1, USB_IRQ_O)
    rdc(UMC_OFS_FRAME_LOW, 32'ha3, "frame low");
    rdc(UMC_OFS_FRAME_HIGH, 32'h25, "frame high");
    rdc(UMC_OFS_EVENT, 2, "frame start");
    e.sof_crc_ok = 0; e.sof_frame = 11'h0ff; h.send(e);
    rdc(UMC_OFS_FRAME_HIGH, 32'h10, "crc bad");
    xfer(1, UMC_OFS_EVENT, 0);
    rdc(UMC_OFS_EVENT, 0, "event clear");
    xfer(1, UMC_OFS_EP_SELECT, 1); xfer(1, UMC_OFS_EP_CONFIG, 2); xfer(1, UMC_OFS_EP_IRQ_EN, 2);
    xfer(1, UMC_OFS_EP_STATUS, 32'h20);
    e = '0; e.ep = 1; h.send(e); #1 `CHK("stall", 1'b1, STALL_ANSWER_O)
    e.stall_sent = 1; h.send(e);
    @(posedge CLK_I); #1 `CHK("stall irq", 1'b1, USB_IRQ_O)
    rdc(UMC_OFS_EP_STATUS, 32'h22, "stall sent");
    xfer(1, UMC_OFS_EP_STATUS, 0);
    rdc(UMC_OFS_EP_STATUS, 0, "stall clear");
    for (i = 0; i < 3; i++) begin
      e = '0; e.ep = 1; e.data_accept = 1; e.data_pid1 = i[0]; h.send(e);
      #1 `CHK("toggle", ~i[0], TX_DATA1_O)
    end
    xfer(1, UMC_OFS_EP_RESET, 2); #1 `CHK("toggle reset", 1'b0, TX_DATA1_O)
    xfer(1, UMC_OFS_EP_SELECT, 2); xfer(1, UMC_OFS_EP_CONFIG, 1); xfer(1, UMC_OFS_EP_STATUS, 32'h20);
    rdc(UMC_OFS_EP_STATUS, 0, "iso stall");
    xfer(1, UMC_OFS_EP_SELECT, 0); xfer(1, UMC_OFS_EP_STATUS, 32'h20);
    e = '0; e.setup_pid = 1; h.send(e);
    rdc(UMC_OFS_EP_STATUS, 32'h40, "setup");
    xfer(1, UMC_OFS_EVENT_EN, 1); xfer(1, UMC_OFS_CONTROL, 1);
    BUS_IDLE_I <= 1;
    for (i = 0; i < 60 && USB_IRQ_O !== 1'b1; i++) @(posedge CLK_I);
    `CHK("suspend", 1'b1, USB_IRQ_O)
    xfer(1, UMC_OFS_EVENT, 0);
    xfer(1, UMC_OFS_CONTROL, 3); #1 `CHK("clock gate", 1'b1, USB_CLOCK_GATE_O)
    @(posedge CLK_I); #1 `CHK("pad idle", 1'b1, PAD_IDLE_O)
    @(posedge CLK_I) begin BUS_ACTIVE_I <= 1; BUS_IDLE_I <= 0; end
    #1 `CHK("resume", 1'b1, RESUME_DET_O)
    @(posedge CLK_I) BUS_ACTIVE_I <= 0;
    e = '0; e.bus_reset_end = 1; h.send(e);
    rdc(UMC_OFS_EVENT, 4, "end of reset");
    rdc(UMC_OFS_CONTROL, 1, "enable kept");
    rdc(UMC_OFS_EVENT_EN, 0, "enables reset");
    xfer(1, UMC_OFS_EVENT, 0);
    rdc(UMC_OFS_EVENT, 0, "eor clear");
    results();
  end
endmodule // umc_misc_ctrl_tb
bind umc_misc_ctrl umc_misc_ctrl_checker chk_u (.*);
